// file: pkg/dsd_pkg.sv
// Purpose: Constants for the data space address decoder
// Assumes: 16-bit data addresses, 8-bit data, 16-bit program words
// Notes:   Offsets are byte addresses in the linear data space
package dsd_pkg;
  // Data space regions
  localparam logic [15:0] REG_BASE    = 16'h0000; // Working registers
  localparam logic [15:0] IO_BASE     = 16'h0020; // I/O register window
  localparam logic [15:0] SRAM_BASE   = 16'h0060; // Internal data SRAM
  localparam logic [15:0] SRAM_LAST   = 16'h025f; // Last SRAM byte
  localparam logic [15:0] USB_BASE    = 16'h1f00; // USB register region
  localparam logic [15:0] USB_LAST    = 16'h1fff; // Top of data space
  localparam logic [15:0] FRAME_HIGH  = 16'h1ffd; // frame_count_high
  localparam logic [15:0] FRAME_LOW   = 16'h1ffc; // frame_count_low
  localparam logic [15:0] PORT_ONE    = 16'h1fb8; // hub_port_one_state
  localparam logic [15:0] PORT_FIVE   = 16'h1fbc; // hub_port_five_state
  // Sizes
  localparam int          NUM_REGS    = 32;       // Working registers
  localparam int          NUM_IO      = 64;       // I/O registers
  localparam int          SRAM_BYTES  = 512;      // SRAM depth
  localparam int          PC_WIDTH    = 16;       // Program counter width
  localparam int          DISP_WIDTH  = 6;        // Displacement width
  // Pointer register numbers
  localparam logic [4:0]  PTR_X_LOW   = 5'h1a;    // first_pointer_low_byte
  localparam logic [4:0]  PTR_Y_LOW   = 5'h1c;    // Second pointer low
  localparam logic [4:0]  PTR_Z_LOW   = 5'h1e;    // Third pointer low
  localparam logic [15:0] RESET_PC    = 16'h0000; // Program counter reset

  // Addressing modes
  typedef enum logic [2:0] {
    DSD_MODE_DIRECT = 3'h0,
    DSD_MODE_DISP   = 3'h1,
    DSD_MODE_IND    = 3'h3,
    DSD_MODE_PREDEC = 3'h2,
    DSD_MODE_POSTINC= 3'h6
  } dsd_mode_t;

  // Region selects
  typedef enum logic [2:0] {
    DSD_RGN_NONE = 3'h0,
    DSD_RGN_REG  = 3'h1,
    DSD_RGN_IO   = 3'h3,
    DSD_RGN_SRAM = 3'h2,
    DSD_RGN_USB  = 3'h6
  } dsd_region_t;

  // ALU operations
  typedef enum logic [2:0] {
    DSD_ALU_ADD = 3'h0,
    DSD_ALU_SUB = 3'h1,
    DSD_ALU_AND = 3'h2,
    DSD_ALU_OR  = 3'h3,
    DSD_ALU_XOR = 3'h4,
    DSD_ALU_BST = 3'h5,
    DSD_ALU_BCL = 3'h6,
    DSD_ALU_MOV = 3'h7
  } dsd_alu_t;
endpackage

// file: src/dsd_region_decode.sv
// Purpose: Map a data address onto its target region
// Assumes: Pure combinational, 16-bit data address
// Notes:   Unmapped holes decode to no region
`timescale 1ns/10ps
module dsd_region_decode (
  input  wire logic [15:0]         addr,      // Data address
  output dsd_pkg::dsd_region_t     region,    // Selected region
  output logic       [9:0]         offset,    // Offset within region
  output logic                     frame_hi,  // Frame count high select
  output logic                     frame_lo,  // Frame count low select
  output logic       [4:0]         port_sel   // One-hot hub port state
);
  // Region compare and offset
  always_comb begin
    region   = dsd_pkg::DSD_RGN_NONE;
    offset   = 10'h000;
    frame_hi = 1'b0;
    frame_lo = 1'b0;
    port_sel = 5'h00;
    if (addr < dsd_pkg::IO_BASE) begin
      region = dsd_pkg::DSD_RGN_REG;
      offset = addr[9:0];
    end else if (addr < dsd_pkg::SRAM_BASE) begin
      region = dsd_pkg::DSD_RGN_IO;
      offset = 10'(addr - dsd_pkg::IO_BASE);
    end else if (addr <= dsd_pkg::SRAM_LAST) begin
      region = dsd_pkg::DSD_RGN_SRAM;
      offset = 10'(addr - dsd_pkg::SRAM_BASE);
    end else if (addr >= dsd_pkg::USB_BASE &&
                 addr <= dsd_pkg::USB_LAST) begin
      region = dsd_pkg::DSD_RGN_USB;
      offset = {2'b00, addr[7:0]};
    end
    frame_hi = (addr == dsd_pkg::FRAME_HIGH);
    frame_lo = (addr == dsd_pkg::FRAME_LOW);
    // Port status registers, port 1 lowest
    if (addr >= dsd_pkg::PORT_ONE && addr <= dsd_pkg::PORT_FIVE) begin
      port_sel = 5'(5'h01 << (addr - dsd_pkg::PORT_ONE));
    end
  end
endmodule

// file: src/dsd_core.sv
// Purpose: Data space addressing, register file, SRAM and program counter
// Assumes: Core sequencer drives one request per cycle on clk
// Notes:   USB and I/O register contents live outside this block
`timescale 1ns/10ps
// Contract
// - Two-register ALU result written same cycle
// - Program memory is 16-bit words, one/two
// - Program counter is 16 bits wide
// - Constant load reads program word addresses 0000..7FFF only (Z shifted right by one)
// - Lowest 96 addresses: registers then I/O
// - Next 512 addresses go to SRAM
// - Five data addressing modes supported
// - Direct addressing reaches whole data space
// - Displacement adds 0..63 to Y or Z; the code also takes X when mem_ptr is 0 or 3
// - Pre-decrement or post-increment writes pointer back
// - Pointers come from registers 26 to 31
// - Top 256 bytes go to USB block
// - Frame count high at 1FFD, low below
// - Hub port states 1..5 ascending addresses
// - Top six registers form three pointers
// - I/O reachable directly and as data; this block only reaches I/O as data space 0x20..0x5F
module dsd_core (
  input  wire logic                    clk,          // 10 MHz clock
  input  wire logic                    arst_n,       // Async reset
  // ALU request
  input  wire logic                    alu_en,       // ALU operation now
  input  wire dsd_pkg::dsd_alu_t       alu_op,       // Operation
  input  wire logic [4:0]              alu_dst,      // Destination reg
  input  wire logic [4:0]              alu_src,      // Source reg
  input  wire logic [2:0]              alu_bit,      // Bit for bit ops
  // Program memory
  input  wire logic                    pc_load,      // Jump target load
  input  wire logic [15:0]             pc_target,    // Jump target
  input  wire logic                    pc_step,      // Advance one word
  input  wire logic                    pc_step_two,  // Two-word instr
  output logic      [15:0]             pc,           // Program counter
  output logic      [15:0]             prog_addr,    // Program address
  input  wire logic [15:0]             prog_word,    // Fetched word
  input  wire logic                    const_load,   // Constant load
  input  wire logic [4:0]              const_dst,    // Constant dest reg
  // Data access request
  input  wire logic                    mem_en,       // Data access now
  input  wire logic                    mem_we,       // Write access
  input  wire dsd_pkg::dsd_mode_t      mem_mode,     // Addressing mode
  input  wire logic [1:0]              mem_ptr,      // 0 X, 1 Y, 2 Z
  input  wire logic [15:0]             mem_direct,   // Direct address
  input  wire logic [5:0]              mem_disp,     // Displacement
  input  wire logic [4:0]              mem_reg,      // Data register
  output logic      [7:0]              mem_rdata,    // Read data
  // I/O window
  output logic                         io_rd,        // I/O read strobe
  output logic                         io_wr,        // I/O write strobe
  output logic      [5:0]              io_addr,      // I/O address
  output logic      [7:0]              io_wdata,     // I/O write data
  input  wire logic [7:0]              io_rdata,     // I/O read data
  // USB register region
  output logic                         usb_rd,       // USB read strobe
  output logic                         usb_wr,       // USB write strobe
  output logic      [7:0]              usb_addr,     // USB byte offset
  output logic      [7:0]              usb_wdata,    // USB write data
  input  wire logic [7:0]              usb_rdata,    // USB read data
  output logic                         frame_count_high, // Frame hi sel
  output logic                         frame_count_low,  // Frame lo sel
  output logic      [4:0]              hub_port_state    // Port 1..5 sel
);
  logic [7:0]  regs [dsd_pkg::NUM_REGS];     // Working registers
  logic [7:0]  next_regs [dsd_pkg::NUM_REGS];
  logic [7:0]  sram [dsd_pkg::SRAM_BYTES];   // Data SRAM
  logic [15:0] next_pc;                      // Next program counter
  logic [15:0] eff_addr;                     // Effective data address
  logic [15:0] ptr_val;                      // Selected pointer
  logic [15:0] ptr_new;                      // Modified pointer
  logic        ptr_wb;                       // Pointer write-back
  logic [4:0]  ptr_low;                      // Pointer low reg number
  logic [7:0]  alu_res;                      // ALU result
  logic [7:0]  next_rdata;                   // Read data next
  logic [7:0]  sram_q;                       // SRAM read word
  dsd_pkg::dsd_region_t region;              // Decoded region
  logic [9:0]  offset;                       // Region offset

  // Low register number of a pointer pair
  function automatic logic [4:0] ptr_base(input logic [1:0] sel);
    unique case (sel)
      2'd1:    ptr_base = dsd_pkg::PTR_Y_LOW;
      2'd2:    ptr_base = dsd_pkg::PTR_Z_LOW;
      default: ptr_base = dsd_pkg::PTR_X_LOW;
    endcase
  endfunction

  // Read a pointer pair as one 16-bit value
  function automatic logic [15:0] ptr_read(input logic [4:0] lo,
                                           input logic [7:0] rl,
                                           input logic [7:0] rh);
    ptr_read = {rh, rl};
  endfunction

  // Address decode
  dsd_region_decode u_decode (
    .addr     (eff_addr),
    .region   (region),
    .offset   (offset),
    .frame_hi (frame_count_high),
    .frame_lo (frame_count_low),
    .port_sel (hub_port_state)
  );

  // Effective address generation
  always_comb begin
    ptr_low = ptr_base(mem_ptr);
    ptr_val = ptr_read(ptr_low, regs[ptr_low], regs[ptr_low + 5'd1]);
    ptr_new = ptr_val;
    ptr_wb  = 1'b0;
    unique case (mem_mode)
      dsd_pkg::DSD_MODE_DIRECT:  eff_addr = mem_direct;
      dsd_pkg::DSD_MODE_DISP:
        eff_addr = ptr_val + {10'h000, mem_disp};
      dsd_pkg::DSD_MODE_IND:     eff_addr = ptr_val;
      dsd_pkg::DSD_MODE_PREDEC: begin
        ptr_new  = ptr_val - 16'h0001;
        eff_addr = ptr_new;
        ptr_wb   = mem_en;
      end
      dsd_pkg::DSD_MODE_POSTINC: begin
        ptr_new  = ptr_val + 16'h0001;
        eff_addr = ptr_val;
        ptr_wb   = mem_en;
      end
      default:                   eff_addr = mem_direct;
    endcase
  end

  // ALU result
  always_comb begin
    unique case (alu_op)
      dsd_pkg::DSD_ALU_ADD: alu_res = regs[alu_dst] + regs[alu_src];
      dsd_pkg::DSD_ALU_SUB: alu_res = regs[alu_dst] - regs[alu_src];
      dsd_pkg::DSD_ALU_AND: alu_res = regs[alu_dst] & regs[alu_src];
      dsd_pkg::DSD_ALU_OR:  alu_res = regs[alu_dst] | regs[alu_src];
      dsd_pkg::DSD_ALU_XOR: alu_res = regs[alu_dst] ^ regs[alu_src];
      dsd_pkg::DSD_ALU_BST: alu_res = regs[alu_dst] | (8'h01 << alu_bit);
      dsd_pkg::DSD_ALU_BCL: alu_res = regs[alu_dst] & ~(8'h01 << alu_bit);
      dsd_pkg::DSD_ALU_MOV: alu_res = regs[alu_src];
    endcase
  end

  // Strobes to the I/O window and USB block
  always_comb begin
    io_rd     = mem_en && !mem_we && region == dsd_pkg::DSD_RGN_IO;
    io_wr     = mem_en && mem_we && region == dsd_pkg::DSD_RGN_IO;
    io_addr   = offset[5:0];
    io_wdata  = regs[mem_reg];
    usb_rd    = mem_en && !mem_we && region == dsd_pkg::DSD_RGN_USB;
    usb_wr    = mem_en && mem_we && region == dsd_pkg::DSD_RGN_USB;
    usb_addr  = offset[7:0];
    usb_wdata = regs[mem_reg];
    sram_q    = sram[offset[8:0]];
  end

  // Read data and register file next state
  always_comb begin
    next_regs  = regs;
    next_rdata = 8'h00;
    if (mem_en && !mem_we) begin
      unique case (region)
        dsd_pkg::DSD_RGN_REG:  next_rdata = regs[offset[4:0]];
        dsd_pkg::DSD_RGN_IO:   next_rdata = io_rdata;
        dsd_pkg::DSD_RGN_SRAM: next_rdata = sram_q;
        dsd_pkg::DSD_RGN_USB:  next_rdata = usb_rdata;
        dsd_pkg::DSD_RGN_NONE: next_rdata = 8'h00;
      endcase
      next_regs[mem_reg] = next_rdata;
    end
    if (mem_en && mem_we && region == dsd_pkg::DSD_RGN_REG) begin
      next_regs[offset[4:0]] = regs[mem_reg];
    end
    if (ptr_wb) begin
      next_regs[ptr_low]        = ptr_new[7:0];
      next_regs[ptr_low + 5'd1] = ptr_new[15:8];
    end
    if (alu_en) begin
      next_regs[alu_dst] = alu_res;
    end
    if (const_load) begin
      next_regs[const_dst] = regs[dsd_pkg::PTR_Z_LOW][0] ?
                             prog_word[15:8] : prog_word[7:0];
    end
  end

  // Program counter and program address
  always_comb begin
    next_pc = pc;
    if (pc_load) begin
      next_pc = pc_target;
    end else if (pc_step) begin
      next_pc = pc + (pc_step_two ? 16'h0002 : 16'h0001);
    end
    prog_addr = const_load ?
                {1'b0, regs[dsd_pkg::PTR_Z_LOW + 5'd1],
                 regs[dsd_pkg::PTR_Z_LOW][7:1]} : pc;
  end

  // Register state
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pc        <= dsd_pkg::RESET_PC;
      mem_rdata <= 8'h00;
      for (int i = 0; i < dsd_pkg::NUM_REGS; i++) begin
        regs[i] <= 8'h00;
      end
    end else begin
      pc        <= next_pc;
      mem_rdata <= next_rdata;
      regs      <= next_regs;
    end
  end

  // SRAM write port; writes to holes are dropped
  always_ff @(posedge clk) begin
    if (mem_en && mem_we && region == dsd_pkg::DSD_RGN_SRAM) begin
      sram[offset[8:0]] <= regs[mem_reg];
    end
  end
endmodule

// file: tb/dsd_far_model.sv
// Purpose: Far side of the decoder: program store, I/O and USB bytes
// Assumes: Read data answers in the same cycle as the strobe
// Notes:   Unstrobed buses show an inverted pattern, never stale data
`timescale 1ns/10ps
module dsd_far_model (
  input  wire logic [15:0] prog_addr, // Word address
  output logic      [15:0] prog_word, // Fetched word
  input  wire logic        io_rd,     // I/O read strobe
  input  wire logic [5:0]  io_addr,   // I/O index
  output logic      [7:0]  io_rdata,  // I/O byte
  input  wire logic        usb_rd,    // USB read strobe
  input  wire logic [7:0]  usb_addr,  // USB offset
  output logic      [7:0]  usb_rdata  // USB byte
);
  // Word is the inverted word address
  assign prog_word = ~prog_addr;
  // I/O byte is 0x40 plus index, inverted when idle
  assign io_rdata  = io_rd ? {2'b01, io_addr} : ~{2'b01, io_addr};
  // USB byte is offset xor 0x5a, inverted when idle
  assign usb_rdata = usb_rd ? (usb_addr ^ 8'h5a) : ~(usb_addr ^ 8'h5a);
endmodule

// file: tb/dsd_core_sva.sv
// Purpose: Port checks of the data space decoder
// Assumes: Bound to dsd_core, checks direct-mode accesses
// Notes:   Strobes are combinational, read data is registered
`timescale 1ns/10ps
module dsd_core_sva (
  input wire logic               clk,
  input wire logic               arst_n,
  input wire logic               pc_load,
  input wire logic        [15:0] pc_target,
  input wire logic               pc_step,
  input wire logic               pc_step_two,
  input wire logic        [15:0] pc,
  input wire logic               mem_en,
  input wire logic               mem_we,
  input wire dsd_pkg::dsd_mode_t mem_mode,
  input wire logic        [15:0] mem_direct,
  input wire logic        [7:0]  mem_rdata,
  input wire logic               io_rd,
  input wire logic               io_wr,
  input wire logic        [5:0]  io_addr,
  input wire logic               usb_rd,
  input wire logic               usb_wr,
  input wire logic        [7:0]  usb_addr,
  input wire logic               frame_count_high,
  input wire logic               frame_count_low,
  input wire logic        [4:0]  hub_port_state
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // Direct-mode access this cycle
  logic dir;
  assign dir = mem_en && mem_mode == dsd_pkg::DSD_MODE_DIRECT;
  // I/O window follows the registers
  chk_io_window: assert property (
    dir && mem_direct inside {[16'h0020:16'h005f]} |->
    (mem_we ? io_wr : io_rd) && io_addr == 6'(mem_direct - 16'h0020))
    else $error("io window decode wrong");
  // SRAM keeps outside strobes quiet
  chk_sram_quiet: assert property (
    dir && mem_direct inside {[16'h0060:16'h025f]} |->
    !(io_rd || io_wr || usb_rd || usb_wr)) else $error("sram leaked");
  // Top 256 bytes go to USB
  chk_usb_route: assert property (
    dir && mem_direct inside {[16'h1f00:16'h1fff]} |->
    (mem_we ? usb_wr : usb_rd) && usb_addr == mem_direct[7:0])
    else $error("usb decode wrong");
  // Frame count byte selects
  chk_frame_sel: assert property (
    dir |-> frame_count_high == (mem_direct == 16'h1ffd) &&
    frame_count_low == (mem_direct == 16'h1ffc)) else $error("frame sel");
  // Hub port one lowest, five highest
  chk_port_sel: assert property (
    dir && mem_direct inside {[16'h1fb8:16'h1fbc]} |->
    hub_port_state == 5'h01 << mem_direct[2:0]) else $error("port sel");
  // Holes read back zero
  chk_hole_zero: assert property (
    dir && !mem_we && mem_direct inside {[16'h0260:16'h1eff]} |=>
    mem_rdata == 8'h00) else $error("hole read not zero");
  // Counter steps one or two words
  chk_pc_step: assert property (
    pc_step && !pc_load |=>
    pc == $past(pc) + ($past(pc_step_two) ? 16'h0002 : 16'h0001))
    else $error("pc step wrong");
  // Jump loads all 16 bits
  chk_pc_load: assert property (
    pc_load |=> pc == $past(pc_target)) else $error("pc load wrong");
endmodule
bind dsd_core dsd_core_sva u_sva (.clk(clk), .arst_n(arst_n),
  .pc_load(pc_load), .pc_target(pc_target), .pc_step(pc_step),
  .pc_step_two(pc_step_two), .pc(pc), .mem_en(mem_en), .mem_we(mem_we),
  .mem_mode(mem_mode), .mem_direct(mem_direct), .mem_rdata(mem_rdata),
  .io_rd(io_rd), .io_wr(io_wr), .io_addr(io_addr), .usb_rd(usb_rd),
  .usb_wr(usb_wr), .usb_addr(usb_addr), .frame_count_high(frame_count_high),
  .frame_count_low(frame_count_low), .hub_port_state(hub_port_state));

// file: tb/test_data_space_address_decoder.sv
// Purpose: Self-checking bench for the data space decoder
// Assumes: Far side model answers fetch, I/O and USB reads
// Notes:   Pointers are loaded by reading I/O bytes into them
`timescale 1ns/10ps
module test_data_space_address_decoder;
  // Stimulus, valued at time zero
  logic               clk = 0, arst_n = 0, pc_load = 0, pc_step = 0;
  logic               pc_step_two = 0, const_load = 0, mem_en = 0;
  logic               mem_we = 0, alu_en = 0;
  dsd_pkg::dsd_alu_t  alu_op = dsd_pkg::DSD_ALU_MOV;
  logic [4:0]         alu_dst = 5'h00, alu_src = 5'h00;
  logic [2:0]         alu_bit = 3'h0;
  logic [4:0]         const_dst = 5'h00, mem_reg = 5'h00;
  logic [1:0]         mem_ptr = 2'h0;
  logic [5:0]         mem_disp = 6'h00;
  logic [15:0]        pc_target = 16'h0000, mem_direct = 16'h0000;
  dsd_pkg::dsd_mode_t mem_mode = dsd_pkg::DSD_MODE_DIRECT;
  // Outputs and far side answers
  logic [15:0]        pc, prog_addr, prog_word;
  logic [7:0]         mem_rdata, io_rdata, usb_addr, usb_rdata;
  logic [5:0]         io_addr;
  logic               io_rd, usb_rd;
  logic               io_wr, usb_wr, frame_count_high, frame_count_low;
  logic [7:0]         io_wdata, usb_wdata;
  logic [4:0]         hub_port_state;
  // Outputs captured mid-cycle while a request stands
  logic [1:0]         wr_seen;
  logic [7:0]         io_wd_seen, usb_wd_seen;
  logic [6:0]         sel_seen;
  int                 fail_count = 0, n_checks = 0;
  // 100 ns clock
  always #50 clk = ~clk;
  dsd_core uut (.clk, .arst_n, .alu_en, .alu_op, .alu_dst, .alu_src,
    .alu_bit, .pc_load, .pc_target,
    .pc_step, .pc_step_two, .pc, .prog_addr, .prog_word, .const_load,
    .const_dst, .mem_en, .mem_we, .mem_mode, .mem_ptr, .mem_direct,
    .mem_disp, .mem_reg, .mem_rdata, .io_rd, .io_wr, .io_addr,
    .io_wdata, .io_rdata, .usb_rd, .usb_wr, .usb_addr, .usb_wdata,
    .usb_rdata, .frame_count_high, .frame_count_low, .hub_port_state);
  dsd_far_model far (.prog_addr, .prog_word, .io_rd, .io_addr, .io_rdata,
    .usb_rd, .usb_addr, .usb_rdata);
  // Count a comparison, report a mismatch
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One data access; the request stays up until the caller changes it,
  // so back-to-back accesses never toggle the enable within one step
  task automatic acc(input logic we, input dsd_pkg::dsd_mode_t m,
    input logic [1:0] p, input logic [15:0] a, input logic [4:0] r);
    mem_we = we;
    mem_mode = m;
    mem_ptr = p;
    mem_direct = a;
    mem_reg = r;
    mem_en = 1'b1;
    #40;
    wr_seen = {usb_wr, io_wr};
    io_wd_seen = io_wdata;
    usb_wd_seen = usb_wdata;
    sel_seen = {frame_count_high, frame_count_low, hub_port_state};
    @(posedge clk);
    #1;
  endtask
  // One ALU operation; the data access is dropped for that cycle
  task automatic alu(input dsd_pkg::dsd_alu_t op, input logic [4:0] d,
    input logic [4:0] s, input logic [2:0] b);
    mem_en = 1'b0;
    alu_op = op;
    alu_dst = d;
    alu_src = s;
    alu_bit = b;
    alu_en = 1'b1;
    @(posedge clk);
    #1;
    alu_en = 1'b0;
  endtask
  // I/O byte into the first pointer, hole read, I/O write
  task automatic t_io;
    acc(0, dsd_pkg::DSD_MODE_DIRECT, 0, 16'h0040, 5'h1a);
    chk(16'(mem_rdata), 16'h0060);
    acc(0, dsd_pkg::DSD_MODE_DIRECT, 0, 16'h0300, 5'h03);
    chk(16'(mem_rdata), 16'h0000);
    acc(1, dsd_pkg::DSD_MODE_DIRECT, 0, 16'h0041, 5'h1a);
    chk({6'h00, wr_seen, io_wd_seen}, 16'h0160);
  endtask
  // Store with post-increment, load with pre-decrement
  task automatic t_ptr;
    acc(0, dsd_pkg::DSD_MODE_DIRECT, 0, 16'h0040, 5'h02);
    acc(1, dsd_pkg::DSD_MODE_POSTINC, 0, 0, 5'h02);
    acc(0, dsd_pkg::DSD_MODE_DIRECT, 0, 16'h001a, 5'h04);
    chk(16'(mem_rdata), 16'h0061);
    acc(0, dsd_pkg::DSD_MODE_PREDEC, 0, 0, 5'h04);
    chk(16'(mem_rdata), 16'h0060);
  endtask
  // Largest displacement off the second pointer, then plain pointer
  task automatic t_disp;
    acc(0, dsd_pkg::DSD_MODE_DIRECT, 0, 16'h0041, 5'h1c);
    mem_disp = 6'h3f;
    acc(1, dsd_pkg::DSD_MODE_DISP, 1, 0, 5'h1c);
    mem_disp = 6'h00;
    acc(0, dsd_pkg::DSD_MODE_DIRECT, 0, 16'h00a0, 5'h04);
    chk(16'(mem_rdata), 16'h0061);
    acc(0, dsd_pkg::DSD_MODE_IND, 0, 0, 5'h04);
    chk(16'(mem_rdata), 16'h0060);
  endtask
  // Frame count, hub ports and region base in the USB block
  task automatic t_usb;
    logic [15:0] a [5] = '{16'h1ffd, 16'h1ffc, 16'h1fb8, 16'h1fbc, 16'h1f00};
    // Expected {frame high, frame low, port 5..1} selects per address
    logic [15:0] e [5] = '{16'h0040, 16'h0020, 16'h0001, 16'h0010, 16'h0000};
    foreach (a[i]) begin
      acc(0, dsd_pkg::DSD_MODE_DIRECT, 0, a[i], 5'h05);
      chk(16'(mem_rdata), 16'(a[i][7:0] ^ 8'h5a));
      chk(16'(sel_seen), e[i]);
    end
    acc(1, dsd_pkg::DSD_MODE_DIRECT, 0, 16'h1ffb, 5'h05);
    chk({6'h00, wr_seen, usb_wd_seen}, 16'h025a);
  endtask
  // Jump near the top, then a two-word step wraps
  task automatic t_pc;
    mem_en = 1'b0;
    pc_target = 16'hfffe;
    pc_load = 1'b1;
    @(posedge clk);
    #1;
    pc_load = 1'b0;
    chk(pc, 16'hfffe);
    pc_step = 1'b1;
    pc_step_two = 1'b1;
    @(posedge clk);
    #1;
    pc_step = 1'b0;
    chk(pc, 16'h0000);
    chk(prog_addr, 16'h0000);
  endtask
  // Constant byte from the word addressed by the third pointer
  task automatic t_const;
    acc(0, dsd_pkg::DSD_MODE_DIRECT, 0, 16'h0040, 5'h1e);
    const_dst = 5'h05;
    mem_en = 1'b0;
    const_load = 1'b1;
    #1;
    chk(prog_addr, 16'h0030);
    @(posedge clk);
    #1;
    const_load = 1'b0;
    acc(0, dsd_pkg::DSD_MODE_DIRECT, 0, 16'h0005, 5'h06);
    chk(16'(mem_rdata), 16'h00cf);
  endtask
  // Two-register add, then a bit set, each written back in one cycle
  task automatic t_alu;
    alu(dsd_pkg::DSD_ALU_ADD, 5'h04, 5'h02, 3'h0);
    acc(0, dsd_pkg::DSD_MODE_DIRECT, 0, 16'h0004, 5'h07);
    chk(16'(mem_rdata), 16'h00c0);
    alu(dsd_pkg::DSD_ALU_BST, 5'h04, 5'h02, 3'h3);
    acc(0, dsd_pkg::DSD_MODE_DIRECT, 0, 16'h0004, 5'h07);
    chk(16'(mem_rdata), 16'h00c8);
  endtask
  // Print verdict and stop
  task automatic final_report;
    if (fail_count == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Reset, then the scenarios
  initial begin
    repeat (20) @(posedge clk);
    #1;
    arst_n = 1'b1;
    t_io;
    t_ptr;
    t_disp;
    t_usb;
    t_pc;
    t_const;
    t_alu;
    final_report;
  end
  // Watchdog against a hang
  initial begin
    #200000;
    fail_count++;
    final_report;
  end
endmodule
